// file: sbc_counter.sv
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// How it works
// [RULE1] Sync mode samples prescaler on second, fourth phases
// [RULE2] Sync mode increments one clock after edge
// [RULE3] Ratio one-to-one passes input straight through
// [RULE4] Other ratios use symmetric ripple divider
// [RULE5] Sync disabled increments directly from input edges
// [RULE6] Async mode counts and overflows during sleep
// [RULE7] Async mode never matches compare units
// [RULE8] Byte reads are unbuffered, so two byte reads may give an incoherent 16-bit value
// [RULE9] Software reads high, low, high again
// [RULE10] Software stops counter before async writes
// [RULE11] Write colliding with increment may be arbitrary
// [RULE12] Oscillator enable bit starts crystal, survives sleep
// [RULE13] Software waits for oscillator start-up
// [RULE14] Trigger-mode compare match clears the counter
// [RULE15] Trigger clear never sets overflow flag
// [RULE16] Software uses timer or sync mode for clear
// [RULE17] Software write beats coincident trigger clear
// [RULE18] Compare value acts as counter period
// [RULE19] Count wraps FFFF to 0000, latching flag
// [RULE20] Source select: instruction cycle or input edges
// [RULE21] Prescale field picks 1, 2, 4, 8; here only the input edges are divided, timer mode ignores the field
// [RULE22] Sync mode stalls in sleep, prescaler runs
module sbc_counter (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // Register bus
  input  wire sbc_pkg::sbc_apb_req_t apb_req,
  output sbc_pkg::sbc_apb_rsp_t      apb_rsp,
  // Count sources
  input  wire logic                  external_count_input,
  input  wire logic                  crystal_input_pin,
  input  wire logic                  sleep,
  // Compare units
  input  wire sbc_pkg::sbc_cmp_t     compare_unit_one,
  input  wire sbc_pkg::sbc_cmp_t     compare_unit_two,
  // Status outputs
  output logic                       crystal_osc_enable_bit,
  output logic                       overflow_irq,
  output logic [15:0]                sixteen_bit_count
);
  import sbc_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       count;
    logic              overflow_irq_flag;
    logic              irq_enable;
    logic [1:0]        phase;
    logic              sync_level;
    logic              sync_edge;
    logic              async_prev;
    logic              osc_on;
    logic              irq;
    sbc_apb_rsp_t      rsp;
  } sbc_state_t;

  sbc_state_t s;
  sbc_state_t next_s;

  logic       count_in;
  logic       presc_out;
  logic       presc_clear;
  logic       bus_setup;
  logic       bus_write;
  logic       wr_lo;
  logic       wr_hi;
  logic       run;
  logic       ext_src;
  logic       sync_dis;
  logic       async_mode;
  logic       sample_phase;
  logic       inc;
  logic       trig;
  logic       wrap;

  // Counting input picks crystal when oscillator is on
  assign count_in = s.ctrl[BIT_OSC_EN] ? crystal_input_pin : external_count_input;

  assign bus_setup   = apb_req.psel && !apb_req.penable;
  assign bus_write   = apb_req.psel && apb_req.penable && s.rsp.pready && apb_req.pwrite;
  assign wr_lo       = bus_write && (apb_req.paddr == ADDR_CNT_LO);
  assign wr_hi       = bus_write && (apb_req.paddr == ADDR_CNT_HI);
  assign presc_clear = wr_lo || wr_hi;

  sbc_presc u_presc (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_level  (count_in),
    .clear     (presc_clear),
    .ratio     (s.ctrl[PS_MSB:PS_LSB]), // [RULE21]
    .presc_out (presc_out)
  );

  always_comb
  begin
    next_s = s;

    run          = s.ctrl[BIT_RUN];
    ext_src      = s.ctrl[BIT_SRC_SEL];
    sync_dis     = s.ctrl[BIT_SYNC_DIS];
    async_mode   = ext_src && sync_dis;
    sample_phase = (s.phase == PH_SECOND) || (s.phase == PH_FOURTH);

    // Phase clocks stop while the processor sleeps
    if (!sleep)
    begin
      next_s.phase = s.phase + 2'h1;
    end

    // Synchroniser, shut off in sleep
    next_s.sync_edge = 1'b0;
    if (sample_phase && !sleep) // [RULE22]
    begin
      next_s.sync_level = presc_out; // [RULE1]
      next_s.sync_edge  = presc_out && !s.sync_level; // [RULE1]
    end

    // Unsynchronised edge detect keeps running in sleep
    next_s.async_prev = presc_out;

    // Increment source
    if (!ext_src)
    begin
      inc = !sleep && (s.phase == PH_FOURTH); // [RULE20]
    end
    else if (sync_dis)
    begin
      inc = presc_out && !s.async_prev; // [RULE5] [RULE6]
    end
    else
    begin
      inc = s.sync_edge; // [RULE2] [RULE20]
    end
    inc = inc && run;

    // Special event trigger; ignored in async mode
    trig = !async_mode && // [RULE7]
           (((compare_unit_one.mode == MODE_SPECIAL_TRIGGER) && (s.count == compare_unit_one.value)) ||
            ((compare_unit_two.mode == MODE_SPECIAL_TRIGGER) && (s.count == compare_unit_two.value))); // [RULE14]

    wrap = 1'b0;

    // Count update: write, then trigger, then increment
    if (wr_lo || wr_hi)
    begin
      if (wr_lo)
      begin
        next_s.count[7:0] = apb_req.pwdata[7:0]; // [RULE17] [RULE11]
      end
      if (wr_hi)
      begin
        next_s.count[15:8] = apb_req.pwdata[7:0]; // [RULE17] [RULE11]
      end
    end
    else if (trig)
    begin
      next_s.count = COUNT_RESET; // [RULE14] [RULE18] [RULE15]
    end
    else if (inc)
    begin
      next_s.count = s.count + COUNT_ONE; // [RULE19]
      wrap         = (s.count == COUNT_TOP); // [RULE19]
    end

    // Register writes
    if (bus_write)
    begin
      case (apb_req.paddr)
        ADDR_CTRL:
        begin
          next_s.ctrl = apb_req.pwdata[CTRL_W-1:0];
        end
        ADDR_FLAG:
        begin
          next_s.overflow_irq_flag = apb_req.pwdata[FLAG_BIT];
        end
        ADDR_ENABLE:
        begin
          next_s.irq_enable = apb_req.pwdata[FLAG_BIT];
        end
        default:
        begin
          next_s.ctrl = s.ctrl;
        end
      endcase
    end

    // Overflow set wins over a coincident clear
    if (wrap)
    begin
      next_s.overflow_irq_flag = 1'b1; // [RULE19] [RULE6]
    end
    next_s.irq = next_s.overflow_irq_flag && next_s.irq_enable; // [RULE19]

    // Oscillator follows its enable, ungated by sleep
    next_s.osc_on = next_s.ctrl[BIT_OSC_EN]; // [RULE12]

    // Bus answer: ready in the first access cycle
    next_s.rsp.pready  = 1'b0;
    next_s.rsp.pslverr = 1'b0;
    next_s.rsp.prdata  = 32'h0000_0000;
    if (bus_setup)
    begin
      next_s.rsp.pready = 1'b1;
      case (apb_req.paddr)
        ADDR_CTRL:
        begin
          next_s.rsp.prdata[CTRL_W-1:0] = s.ctrl;
        end
        ADDR_FLAG:
        begin
          next_s.rsp.prdata[FLAG_BIT] = s.overflow_irq_flag;
        end
        ADDR_ENABLE:
        begin
          next_s.rsp.prdata[FLAG_BIT] = s.irq_enable;
        end
        ADDR_CNT_LO:
        begin
          next_s.rsp.prdata[7:0] = s.count[7:0]; // [RULE8]
        end
        ADDR_CNT_HI:
        begin
          next_s.rsp.prdata[7:0] = s.count[15:8]; // [RULE8]
        end
        default:
        begin
          next_s.rsp.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s       <= '0;
      s.ctrl  <= CTRL_RESET;
      s.count <= COUNT_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign apb_rsp                = s.rsp;
  assign crystal_osc_enable_bit = s.osc_on;
  assign overflow_irq           = s.irq;
  assign sixteen_bit_count      = s.count;

endmodule // sbc_counter

// file: sbc_pkg.sv
package sbc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAG    = 8'h0C;
  localparam logic [7:0] IDX_ENABLE  = 8'h8C;
  localparam logic [7:0] IDX_CNT_LO  = 8'h0E;
  localparam logic [7:0] IDX_CNT_HI  = 8'h0F;
  localparam logic [7:0] IDX_CTRL    = 8'h10;
  localparam int         ADDR_W      = 10;

  localparam logic [ADDR_W-1:0] ADDR_FLAG   = {IDX_FLAG,   2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = {IDX_ENABLE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO = {IDX_CNT_LO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI = {IDX_CNT_HI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = {IDX_CTRL,   2'b00};

  // Control register fields
  localparam int         CTRL_W       = 6;
  localparam int         BIT_RUN      = 0;
  localparam int         BIT_SRC_SEL  = 1;
  localparam int         BIT_SYNC_DIS = 2;
  localparam int         BIT_OSC_EN   = 3;
  localparam int         PS_LSB       = 4;
  localparam int         PS_MSB       = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

  localparam int         FLAG_BIT     = 0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP   = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE   = 16'h0001;
  localparam logic [3:0]  MODE_SPECIAL_TRIGGER = 4'hB;

  // Prescale ratios
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV2 = 2'h1;
  localparam logic [1:0] PS_DIV4 = 2'h2;
  localparam logic [1:0] PS_DIV8 = 2'h3;

  // Instruction cycle phases, one clock each
  localparam logic [1:0] PH_FIRST  = 2'h0;
  localparam logic [1:0] PH_SECOND = 2'h1;
  localparam logic [1:0] PH_THIRD  = 2'h2;
  localparam logic [1:0] PH_FOURTH = 2'h3;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } sbc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } sbc_apb_rsp_t;

  typedef struct packed {
    logic [3:0]  mode;
    logic [15:0] value;
  } sbc_cmp_t;

endpackage

// file: sbc_presc.sv
`timescale 1ns/1ps
module sbc_presc (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Count input and control
  input  wire logic       in_level,
  input  wire logic       clear,
  input  wire logic [1:0] ratio,
  // Prescaled level
  output logic            presc_out
);
  import sbc_pkg::*;

  typedef struct packed {
    logic       prev;
    logic [2:0] cnt;
    logic       out;
  } sbc_presc_state_t;

  sbc_presc_state_t s;
  sbc_presc_state_t next_s;

  always_comb
  begin
    next_s      = s;
    next_s.prev = in_level;
    if (clear)
    begin
      next_s.cnt = 3'h0;
    end
    else if (in_level && !s.prev)
    begin
      next_s.cnt = s.cnt + 3'h1;
    end
    case (ratio)
      PS_DIV1: next_s.out = in_level; // [RULE3]
      PS_DIV2: next_s.out = s.cnt[0]; // [RULE4]
      PS_DIV4: next_s.out = s.cnt[1]; // [RULE4]
      PS_DIV8: next_s.out = s.cnt[2]; // [RULE4]
      default: next_s.out = in_level;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign presc_out = s.out;

endmodule // sbc_presc

// file: sbc_checker.sv
`timescale 1ns/1ps
module sbc_checker (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // Bus and sources
  input  wire sbc_pkg::sbc_apb_req_t apb_req,
  input  wire sbc_pkg::sbc_apb_rsp_t apb_rsp,
  input  wire logic                  external_count_input,
  input  wire logic                  crystal_input_pin,
  input  wire logic                  sleep,
  input  wire sbc_pkg::sbc_cmp_t     compare_unit_one,
  input  wire sbc_pkg::sbc_cmp_t     compare_unit_two,
  // Outputs
  input  wire logic                  crystal_osc_enable_bit,
  input  wire logic                  overflow_irq,
  input  wire logic [15:0]           sixteen_bit_count
);
  import sbc_pkg::*;
  logic [5:0] ctl;
  logic       en;
  logic [3:0] idle;
  wire acc = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  wire wr_hi = acc && apb_req.paddr == ADDR_CNT_HI;
  wire wr_cnt = wr_hi || (acc && apb_req.paddr == ADDR_CNT_LO);
  wire asy = ctl[BIT_SRC_SEL] && ctl[BIT_SYNC_DIS];
  wire syn = ctl[BIT_SRC_SEL] && !ctl[BIT_SYNC_DIS];
  wire tmr = ctl[BIT_RUN] && !ctl[BIT_SRC_SEL];
  wire hit = (compare_unit_one.mode == MODE_SPECIAL_TRIGGER && sixteen_bit_count == compare_unit_one.value)
          || (compare_unit_two.mode == MODE_SPECIAL_TRIGGER && sixteen_bit_count == compare_unit_two.value);
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl  <= CTRL_RESET;
      en   <= 1'b0;
      idle <= 4'h0;
    end
    else
    begin
      if (acc && apb_req.paddr == ADDR_CTRL)
        ctl <= apb_req.pwdata[CTRL_W-1:0];
      if (acc && apb_req.paddr == ADDR_ENABLE)
        en <= apb_req.pwdata[FLAG_BIT];
      idle <= (!tmr || sleep || $changed(sixteen_bit_count)) ? 4'h0 : idle + 4'h1;
    end
  end
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_answer_next: assert property (s_setup |=> apb_rsp.pready) else $error("no answer after setup");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("ready held");
  a_trig_clear: assert property (hit && !asy && !wr_cnt |=> sixteen_bit_count == COUNT_RESET)
    else $error("trigger did not clear");
  a_async_nomatch: assert property (hit && asy && !wr_cnt && sixteen_bit_count != COUNT_TOP
    |=> sixteen_bit_count != COUNT_RESET) else $error("async cleared");
  a_write_wins: assert property (wr_hi |=> sixteen_bit_count[15:8] == $past(apb_req.pwdata[7:0]))
    else $error("write lost");
  a_count_step: assert property ($changed(sixteen_bit_count) |->
    sixteen_bit_count == $past(sixteen_bit_count) + COUNT_ONE || sixteen_bit_count == COUNT_RESET || $past(wr_cnt))
    else $error("bad step");
  a_timer_rate: assert property (idle <= 4'h4) else $error("timer stalled");
  a_sleep_hold: assert property (sleep && $past(sleep, 3) && syn && !wr_cnt && !hit
    |=> $stable(sixteen_bit_count)) else $error("sync counted in sleep");
  a_irq_enable: assert property (overflow_irq |-> en) else $error("irq not enabled");
endmodule // sbc_checker
bind sbc_counter sbc_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .external_count_input(external_count_input), .crystal_input_pin(crystal_input_pin), .sleep(sleep),
  .compare_unit_one(compare_unit_one), .compare_unit_two(compare_unit_two),
  .crystal_osc_enable_bit(crystal_osc_enable_bit), .overflow_irq(overflow_irq),
  .sixteen_bit_count(sixteen_bit_count));

// file: sbc_partner.sv
`timescale 1ns/1ps
module sbc_partner (
  // Clock
  input  wire logic       clk_sys,
  // Controls
  input  wire logic       run,
  input  wire logic       osc_on,
  input  wire logic [3:0] half,
  // Count sources
  output logic            ext_clk,
  output logic            xtal
);
  logic [3:0] cnt = 4'h0;
  initial ext_clk = 1'b0;
  initial xtal = 1'b0;
  always @(posedge clk_sys)
  begin
    cnt <= (cnt >= half) ? 4'h0 : cnt + 4'h1;
    if (cnt >= half && run)
      ext_clk <= !ext_clk;
    if (cnt >= half && run && osc_on)
      xtal <= !xtal;
  end
endmodule // sbc_partner

// file: sbc_counter_tb_top.sv
`timescale 1ns/1ps
module sbc_counter_tb_top;
  import sbc_pkg::*;
  logic         clk_sys = 1'b0;
  logic         rst_b = 1'b0;
  logic         sleep = 1'b0;
  logic         prun = 1'b0;
  logic [3:0]   half = 4'h2;
  sbc_apb_req_t req = '0;
  sbc_apb_rsp_t rsp;
  sbc_cmp_t     cu1 = '0;
  sbc_cmp_t     cu2 = '0;
  logic         ext, xtal, osc, irq;
  logic [15:0]  cnt;
  logic [32:0]  expq[$];
  logic [9:0]   adr[5] = '{ADDR_FLAG, ADDR_ENABLE, ADDR_CNT_LO, ADDR_CNT_HI, ADDR_CTRL};
  int           n_errors = 0;
  int           tests_run = 0;
  integer       seed = 32'hB65008C7;
  always #50 clk_sys = !clk_sys;
  sbc_counter u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
    .external_count_input(ext), .crystal_input_pin(xtal), .sleep(sleep), .compare_unit_one(cu1),
    .compare_unit_two(cu2), .crystal_osc_enable_bit(osc), .overflow_irq(irq), .sixteen_bit_count(cnt));
  sbc_partner u_src (.clk_sys(clk_sys), .run(prun), .osc_on(osc), .half(half), .ext_clk(ext), .xtal(xtal));
  task automatic results;
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic lim(input int i);
    if (i >= 200)
    begin
      n_errors++;
      results();
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      i++;
    end while (rsp.pready !== 1'b1 && i < 200);
    lim(i);
    req <= '0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  always @(posedge clk_sys)
    if (rsp.pready === 1'b1 && !req.pwrite && expq.size() > 0)
      chk({rsp.pslverr, rsp.prdata}, expq.pop_front());
  initial
  begin
    int i, m, ps, h, v, u;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (i = 0; i < 5; i++)
      rd(adr[i], 33'h0);
    rd(10'h3FC, {1'b1, 32'h0});
    wr(ADDR_CTRL, 32'hFE);
    rd(ADDR_CTRL, 33'h3E);
    chk(33'(osc), 33'h1);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CNT_HI, 32'hFF);
    wr(ADDR_CNT_LO, 32'hFE);
    wr(ADDR_ENABLE, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    for (i = 0; i < 200 && irq !== 1'b1; i++)
      @(posedge clk_sys);
    lim(i);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_FLAG, 33'h1);
    rd(ADDR_CNT_HI, 33'h0);
    wr(ADDR_FLAG, 32'h0);
    rd(ADDR_FLAG, 33'h0);
    for (m = 0; m < 3; m++)
      for (ps = 0; ps < 4; ps++)
      begin
        h = 2 + $unsigned($random(seed)) % 4;
        half <= h[3:0];
        cu2 <= (m == 1) ? '{MODE_SPECIAL_TRIGGER, 16'h0005} : '0;
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CNT_LO, 32'h0);
        wr(ADDR_CNT_HI, 32'h0);
        sleep <= (m > 0);
        wr(ADDR_CTRL, {26'h0, ps[1:0], (m == 1) ? 4'hF : 4'h3});
        repeat (4) @(posedge clk_sys);
        prun <= 1'b1;
        repeat (32 * (h + 1)) @(posedge clk_sys);
        prun <= 1'b0;
        repeat (8) @(posedge clk_sys);
        sleep <= 1'b0;
        wr(ADDR_CTRL, 32'h0);
        rd(ADDR_CNT_HI, 33'h0);
        rd(ADDR_CNT_LO, (m == 2) ? 33'h0 : 33'(16 >> ps));
        rd(ADDR_CNT_HI, 33'h0);
      end
    for (u = 0; u < 2; u++)
    begin
      v = 8 + $unsigned($random(seed)) % 16;
      wr(ADDR_CNT_LO, 32'h0);
      wr(ADDR_CNT_HI, 32'h0);
      cu1 <= (u == 0) ? '{MODE_SPECIAL_TRIGGER, v[15:0]} : '0;
      cu2 <= (u == 1) ? '{MODE_SPECIAL_TRIGGER, v[15:0]} : '0;
      wr(ADDR_CTRL, 32'h1);
      repeat (12 * v) @(posedge clk_sys);
      i = 0;
      do
      begin
        @(posedge clk_sys);
        i++;
      end while (cnt !== v[15:0] - 16'h2 && i < 200);
      lim(i);
      i = 0;
      do
      begin
        @(posedge clk_sys);
        i++;
      end while (cnt !== v[15:0] - 16'h1 && i < 200);
      lim(i);
      @(posedge clk_sys);
      wr(ADDR_CNT_HI, 32'h12);
      wr(ADDR_CTRL, 32'h0);
      rd(ADDR_CNT_HI, 33'h12);
      rd(ADDR_CNT_LO, 33'(v + 1));
      rd(ADDR_FLAG, 33'h0);
      cu1 <= '0;
      cu2 <= '0;
    end
    repeat (4) @(posedge clk_sys);
    results();
  end
endmodule // sbc_counter_tb_top
